// >>> inc/fmu_pkg.sv
// Constants and types shared by the fixed map translator files
package fmu_pkg;

  // Register byte offsets
  localparam logic [4:0] FMU_OFF_CONFIG   = 5'h00;
  localparam logic [4:0] FMU_OFF_PSTATUS  = 5'h04;
  localparam logic [4:0] FMU_OFF_EVENT    = 5'h08;
  localparam logic [4:0] FMU_OFF_MASK     = 5'h0C;
  localparam logic [4:0] FMU_OFF_ERR_VA   = 5'h10;

  // Attribute field positions in the configuration register
  localparam int FMU_UK_LSB  = 28;
  localparam int FMU_UK_MSB  = 30;
  localparam int FMU_USR_LSB = 25;
  localparam int FMU_USR_MSB = 27;
  localparam int FMU_CK_LSB  = 0;
  localparam int FMU_CK_MSB  = 2;

  // Error level flag position in the processor status register
  localparam int FMU_ERL_BIT = 2;

  // Event bits
  localparam int FMU_EV_ADDR_ERR = 0;
  localparam int FMU_EV_ERL_USER = 1;
  localparam int FMU_EV_W        = 2;

  // Reset values
  localparam logic [2:0]  FMU_ATTR_RST  = 3'h2;
  localparam logic        FMU_ERL_RST   = 1'b1;
  localparam logic [31:0] FMU_WORD_ZERO = 32'h0000_0000;

  // Cache coherency attribute codes
  localparam logic [2:0] FMU_CCA_WT_NOALLOC = 3'h0;
  localparam logic [2:0] FMU_CCA_WT_ALLOC   = 3'h1;
  localparam logic [2:0] FMU_CCA_UNCACHED   = 3'h2;
  localparam logic [2:0] FMU_CCA_UNC_ACCEL  = 3'h7;

  // Segment boundaries, selected by the top three address bits
  localparam logic [2:0]  FMU_SEG_CK     = 3'h4;
  localparam logic [2:0]  FMU_SEG_UCK    = 3'h5;
  localparam logic [2:0]  FMU_SEG_SUP    = 3'h6;
  localparam logic [2:0]  FMU_SEG_UK     = 3'h7;
  localparam logic [31:0] FMU_UNMAP_MASK = 32'h1FFF_FFFF;

  // Default offsets for the mapped segments
  localparam logic [31:0] FMU_USR_OFS_DEF = 32'h4000_0000;
  localparam logic [31:0] FMU_SUP_OFS_DEF = 32'h0000_0000;

  typedef enum logic [1:0] {
    FMU_MODE_KERNEL,
    FMU_MODE_SUPER,
    FMU_MODE_USER
  } fmu_mode_t;

  typedef enum logic [1:0] {
    FMU_BUS_IDLE,
    FMU_BUS_ANSWER,
    FMU_BUS_DONE
  } fmu_bus_t;

endpackage

// >>> inc/fmu_xlate_if.sv
// Bundle between the register side and the translator core
`timescale 1ns/1ns
interface fmu_xlate_if;
  import fmu_pkg::*;
  logic        valid;
  logic [31:0] va;
  fmu_mode_t   mode;
  logic [2:0]  uk_attr;
  logic [2:0]  usr_attr;
  logic [2:0]  ck_attr;
  logic        error_level_flag;
  logic [31:0] pa;
  logic [2:0]  cca;
  logic        cacheable;
  logic        write_back;
  logic        write_alloc;
  logic        unc_accel;
  logic        addr_err;
  logic        erl_user;

  modport ctl (output valid, va, mode, uk_attr, usr_attr, ck_attr, error_level_flag,
               input pa, cca, cacheable, write_back, write_alloc, unc_accel, addr_err, erl_user);
  modport xl  (input valid, va, mode, uk_attr, usr_attr, ck_attr, error_level_flag,
               output pa, cca, cacheable, write_back, write_alloc, unc_accel, addr_err, erl_user);
endinterface

// >>> verilog/fmu_xlate.sv
// Combinational segment decode, address map and attribute decode
`timescale 1ns/1ns
module fmu_xlate
  import fmu_pkg::*;
#(
  parameter logic [31:0] USR_OFS = FMU_USR_OFS_DEF,
  parameter logic [31:0] SUP_OFS = FMU_SUP_OFS_DEF
) (
  fmu_xlate_if.xl x
);

  logic [2:0] seg;
  logic [2:0] attr;

  // Only the 32-bit address form exists here
  assign seg = x.va[31:29];

  always_comb begin
    x.pa       = x.va;
    attr       = FMU_CCA_UNCACHED;
    x.erl_user = 1'b0;
    if (seg == FMU_SEG_CK) begin
      x.pa = x.va & FMU_UNMAP_MASK;
      attr = x.ck_attr;
    end else if (seg == FMU_SEG_UCK) begin
      x.pa = x.va & FMU_UNMAP_MASK;
      attr = FMU_CCA_UNCACHED;
    end else if (seg == FMU_SEG_SUP || seg == FMU_SEG_UK) begin
      x.pa = x.va + SUP_OFS;
      attr = x.uk_attr;
    end else if (x.error_level_flag) begin
      // Unmapped window at physical zero, never cached
      x.pa       = x.va;
      attr       = FMU_CCA_UNCACHED;
      x.erl_user = x.valid;
    end else begin
      x.pa = x.va + USR_OFS;
      attr = x.usr_attr;
    end
  end

  // Attribute decode
  always_comb begin
    x.cca         = attr;
    x.cacheable   = 1'b1;
    x.write_back  = 1'b0;
    x.write_alloc = 1'b0;
    x.unc_accel   = 1'b0;
    case (attr)
      FMU_CCA_WT_NOALLOC: x.write_alloc = 1'b0;
      FMU_CCA_WT_ALLOC:   x.write_alloc = 1'b1;
      FMU_CCA_UNCACHED:   x.cacheable   = 1'b0;
      FMU_CCA_UNC_ACCEL: begin
        x.cacheable = 1'b0;
        x.unc_accel = 1'b1;
      end
      default: begin
        x.write_back  = 1'b1;
        x.write_alloc = 1'b1;
      end
    endcase
  end

  // Address errors only; no refill or invalid exceptions exist
  always_comb begin
    x.addr_err = 1'b0;
    if (x.valid) begin
      if (x.mode == FMU_MODE_USER) begin
        x.addr_err = x.va[31];
      end else if (x.mode == FMU_MODE_SUPER) begin
        x.addr_err = x.va[31] && (seg != FMU_SEG_SUP);
      end
    end
  end

endmodule

// >>> verilog/fmu_top.sv
// Fixed map translator top: Avalon-MM registers, events and translator
`timescale 1ns/1ns

module fmu_top
  import fmu_pkg::*;
#(
  parameter logic [31:0] USR_OFS = FMU_USR_OFS_DEF,
  parameter logic [31:0] SUP_OFS = FMU_SUP_OFS_DEF
) (
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic [4:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        VA_VALID_I,
  input  wire logic [31:0] VA_I,
  input  wire logic [1:0]  MODE_I,
  output logic      [31:0] PA_O,
  output logic      [2:0]  CCA_O,
  output logic             CACHEABLE_O,
  output logic             WRITE_BACK_O,
  output logic             WRITE_ALLOC_O,
  output logic             UNCACHED_ACCEL_O,
  output logic             ADDR_ERR_O,
  output logic             ERROR_LEVEL_O,
  output logic             IRQ_O
);

  fmu_xlate_if xif ();

  fmu_bus_t           bus_r;
  fmu_bus_t           bus_nxt;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;
  logic [2:0]         uk_attr_r;
  logic [2:0]         usr_attr_r;
  logic [2:0]         ck_attr_r;
  logic               erl_r;
  logic [FMU_EV_W-1:0] event_r;
  logic [FMU_EV_W-1:0] event_nxt;
  logic [FMU_EV_W-1:0] mask_r;
  logic [FMU_EV_W-1:0] hit;
  logic [31:0]        err_va_r;
  logic               irq_r;
  logic               wr_take;
  logic [31:0]        wr_word;
  logic [31:0]        cfg_word;
  logic [31:0]        pst_word;

  // Merge write data under byte enables
  function automatic logic [31:0] fmu_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register images as software sees them
  always_comb begin
    cfg_word = FMU_WORD_ZERO;
    cfg_word[FMU_UK_MSB:FMU_UK_LSB]   = uk_attr_r;
    cfg_word[FMU_USR_MSB:FMU_USR_LSB] = usr_attr_r;
    cfg_word[FMU_CK_MSB:FMU_CK_LSB]   = ck_attr_r;
    pst_word = FMU_WORD_ZERO;
    pst_word[FMU_ERL_BIT] = erl_r;
  end

  // Pipeline side feeds the translator directly, same clock domain
  assign xif.valid    = VA_VALID_I;
  assign xif.va       = VA_I;
  assign xif.mode     = fmu_mode_t'(MODE_I);
  assign xif.uk_attr  = uk_attr_r;
  assign xif.usr_attr = usr_attr_r;
  assign xif.ck_attr  = ck_attr_r;
  assign xif.error_level_flag      = erl_r;

  fmu_xlate #(
    .USR_OFS (USR_OFS),
    .SUP_OFS (SUP_OFS)
  ) u_xlate (
    .x (xif)
  );

  // Translation results bypass flops so tag compare is not delayed
  assign PA_O             = xif.pa;
  assign CCA_O            = xif.cca;
  assign CACHEABLE_O      = xif.cacheable;
  assign WRITE_BACK_O     = xif.write_back;
  assign WRITE_ALLOC_O    = xif.write_alloc;
  assign UNCACHED_ACCEL_O = xif.unc_accel;
  assign ADDR_ERR_O       = xif.addr_err;

  // Bus handshake: one wait cycle, then one answer cycle, then a gap
  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      FMU_BUS_IDLE: begin
        if (AVS_READ_I || AVS_WRITE_I) begin
          bus_nxt = FMU_BUS_ANSWER;
        end
      end
      FMU_BUS_ANSWER: bus_nxt = FMU_BUS_DONE;
      default:        bus_nxt = FMU_BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      bus_r <= FMU_BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // Waitrequest low exactly in the answer cycle
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= (bus_nxt != FMU_BUS_ANSWER);
    end
  end

  assign wr_take = AVS_WRITE_I && (bus_r == FMU_BUS_ANSWER);

  // Read data captured as the answer cycle opens; unmapped reads as zero
  always_comb begin
    rdata_nxt = FMU_WORD_ZERO;
    if (AVS_ADDRESS_I == FMU_OFF_CONFIG) begin
      rdata_nxt = cfg_word;
    end else if (AVS_ADDRESS_I == FMU_OFF_PSTATUS) begin
      rdata_nxt = pst_word;
    end else if (AVS_ADDRESS_I == FMU_OFF_EVENT) begin
      rdata_nxt[FMU_EV_W-1:0] = event_r;
    end else if (AVS_ADDRESS_I == FMU_OFF_MASK) begin
      rdata_nxt[FMU_EV_W-1:0] = mask_r;
    end else if (AVS_ADDRESS_I == FMU_OFF_ERR_VA) begin
      rdata_nxt = err_va_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rdata_r <= FMU_WORD_ZERO;
    end else if (AVS_READ_I && bus_nxt == FMU_BUS_ANSWER) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign AVS_READDATA_O = rdata_r;

  // Configuration fields steer the attribute decode
  assign wr_word = fmu_merge(cfg_word, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      uk_attr_r  <= FMU_ATTR_RST;
      usr_attr_r <= FMU_ATTR_RST;
      ck_attr_r  <= FMU_ATTR_RST;
    end else if (wr_take && AVS_ADDRESS_I == FMU_OFF_CONFIG) begin
      uk_attr_r  <= wr_word[FMU_UK_MSB:FMU_UK_LSB];
      usr_attr_r <= wr_word[FMU_USR_MSB:FMU_USR_LSB];
      ck_attr_r  <= wr_word[FMU_CK_MSB:FMU_CK_LSB];
    end
  end

  // Error level comes out of reset set, as after a reset exception
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      erl_r <= FMU_ERL_RST;
    end else if (wr_take && AVS_ADDRESS_I == FMU_OFF_PSTATUS && AVS_BYTEENABLE_I[0]) begin
      erl_r <= AVS_WRITEDATA_I[FMU_ERL_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ERROR_LEVEL_O <= FMU_ERL_RST;
    end else begin
      ERROR_LEVEL_O <= erl_r;
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  assign hit[FMU_EV_ADDR_ERR] = xif.addr_err;
  assign hit[FMU_EV_ERL_USER] = xif.erl_user;

  always_comb begin
    event_nxt = event_r;
    if (wr_take && AVS_ADDRESS_I == FMU_OFF_EVENT && AVS_BYTEENABLE_I[0]) begin
      event_nxt = event_r & ~AVS_WRITEDATA_I[FMU_EV_W-1:0];
    end
    event_nxt = event_nxt | hit;
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      event_r <= '0;
    end else begin
      event_r <= event_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      mask_r <= '0;
    end else if (wr_take && AVS_ADDRESS_I == FMU_OFF_MASK && AVS_BYTEENABLE_I[0]) begin
      mask_r <= AVS_WRITEDATA_I[FMU_EV_W-1:0];
    end
  end

  // Keeps the most recent faulting address for the handler
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      err_va_r <= FMU_WORD_ZERO;
    end else if (xif.addr_err) begin
      err_va_r <= VA_I;
    end
  end

  // Registered from event_nxt, so the line changes in the same cycle as the status bit
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(event_nxt & mask_r);
    end
  end

  assign IRQ_O = irq_r;

endmodule

// >>> verification/fmu_pipe_model.sv
// Pipeline side model driving virtual addresses
`timescale 1ns/1ns
module fmu_pipe_model (
  input  wire logic        clk_i,
  output logic             va_valid_o,
  output logic      [31:0] va_o,
  output logic      [1:0]  mode_o
);
  initial begin
    va_valid_o = 1'b0;
    va_o = 32'h0000_0000;
    mode_o = 2'h0;
  end
  // Changes only after an edge, so the translator sees a clean address
  task automatic issue(input logic v, input logic [31:0] a, input logic [1:0] m);
    @(posedge clk_i);
    va_valid_o <= v;
    va_o <= a;
    mode_o <= m;
  endtask
endmodule

// >>> verification/fmu_top_chk.sv
// Port assertions for the fixed map translator
`timescale 1ns/1ns
module fmu_top_chk
  import fmu_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RESETN_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        VA_VALID_I,
  input wire logic [31:0] VA_I,
  input wire logic [1:0]  MODE_I,
  input wire logic [31:0] PA_O,
  input wire logic [2:0]  CCA_O,
  input wire logic        CACHEABLE_O,
  input wire logic        WRITE_BACK_O,
  input wire logic        WRITE_ALLOC_O,
  input wire logic        UNCACHED_ACCEL_O,
  input wire logic        ADDR_ERR_O,
  input wire logic        ERROR_LEVEL_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_req;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  // Error level output lags the flag by one cycle
  sequence s_usr_erl;
    !VA_I[31] ##1 ERROR_LEVEL_O;
  endsequence
  a_bus_answer: assert property (s_req |-> ##[1:3] !AVS_WAITREQUEST_O)
    else $error("bus request not answered");
  a_wait_pulse: assert property ($fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  a_cache_dec: assert property (CACHEABLE_O == (CCA_O != 3'h2 && CCA_O != 3'h7))
    else $error("cacheable flag wrong");
  a_wb_dec: assert property (WRITE_BACK_O == (CCA_O >= 3'h3 && CCA_O <= 3'h6))
    else $error("write back flag wrong");
  a_alloc_dec: assert property (WRITE_ALLOC_O == (CCA_O >= 3'h3 && CCA_O <= 3'h6 || CCA_O == 3'h1))
    else $error("allocate flag wrong");
  a_accel_dec: assert property (UNCACHED_ACCEL_O == (CCA_O == 3'h7))
    else $error("accelerated flag wrong");
  a_uncached_seg: assert property (VA_I[31:29] == FMU_SEG_UCK |->
    CCA_O == FMU_CCA_UNCACHED && PA_O == (VA_I & FMU_UNMAP_MASK)) else $error("uncached segment wrong");
  a_cached_map: assert property (VA_I[31:29] == FMU_SEG_CK |-> PA_O == (VA_I & FMU_UNMAP_MASK))
    else $error("cached segment address wrong");
  a_addr_err: assert property (ADDR_ERR_O == (VA_VALID_I && VA_I[31] &&
    (MODE_I == 2'h2 || MODE_I == 2'h1 && VA_I[31:29] != FMU_SEG_SUP))) else $error("address error wrong");
  a_erl_unmap: assert property (s_usr_erl |-> $past(CCA_O) == FMU_CCA_UNCACHED
    && $past(PA_O) == $past(VA_I)) else $error("user segment not unmapped");
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the fixed map translator
`timescale 1ns/1ns
module testbench
  import fmu_pkg::*;
;
  localparam logic [31:0] USR = 32'h4000_0000;
  localparam logic [31:0] SUP = 32'h0100_0000;
  logic        clk;
  logic        rstn;
  logic [4:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wreq;
  logic        va_valid;
  logic [31:0] va;
  logic [1:0]  mode;
  logic [31:0] pa;
  logic [2:0]  cca;
  logic [4:0]  flg;
  logic        erl_o;
  logic        irq;
  logic [31:0] q;
  logic [31:0] cfg;
  logic        error_level_flag;
  int          err_count;
  int          checks_done;
  fmu_pipe_model pipe (.clk_i(clk), .va_valid_o(va_valid), .va_o(va), .mode_o(mode));
  fmu_top #(.USR_OFS(USR), .SUP_OFS(SUP)) dut (.CLK_I(clk), .RESETN_I(rstn), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .VA_VALID_I(va_valid), .VA_I(va), .MODE_I(mode),
    .PA_O(pa), .CCA_O(cca), .CACHEABLE_O(flg[4]), .WRITE_BACK_O(flg[3]), .WRITE_ALLOC_O(flg[2]),
    .UNCACHED_ACCEL_O(flg[1]), .ADDR_ERR_O(flg[0]), .ERROR_LEVEL_O(erl_o), .IRQ_O(irq));
  always #50 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    // Waitrequest and read data are taken at the same rising edge
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (i == 20) begin
      err_count++;
      finish_test();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Reference translation from the segment map
  task automatic xl(input logic v, input logic [31:0] a, input logic [1:0] m);
    logic [31:0] p;
    logic [2:0]  c;
    logic        wb;
    pipe.issue(v, a, m);
    @(negedge clk);
    if (!a[31]) begin
      p = error_level_flag ? a : a + USR;
      c = error_level_flag ? FMU_CCA_UNCACHED : cfg[27:25];
    end else if (a[31:29] == FMU_SEG_CK) begin
      p = a & FMU_UNMAP_MASK;
      c = cfg[2:0];
    end else if (a[31:29] == FMU_SEG_UCK) begin
      p = a & FMU_UNMAP_MASK;
      c = FMU_CCA_UNCACHED;
    end else begin
      p = a + SUP;
      c = cfg[30:28];
    end
    wb = c >= 3'h3 && c <= 3'h6;
    chk("pa", pa, p);
    chk("cca", {29'h0, cca}, {29'h0, c});
    chk("flags", {27'h0, flg}, {27'h0, c != 3'h2 && c != 3'h7, wb, wb || c == 3'h1, c == 3'h7,
      v && a[31] && (m == 2'h2 || m == 2'h1 && a[31:29] != FMU_SEG_SUP)});
  endtask
  task automatic wirq(input logic e);
    repeat (4) begin
      @(negedge clk);
      if (irq === e) break;
    end
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    adr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    be = 4'hF;
    void'($urandom(38));
    cfg = 32'h2400_0002;
    error_level_flag = 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("erl_rst", {31'h0, erl_o}, 32'h1);
    bus(1'b0, FMU_OFF_CONFIG, 32'h0);
    chk("cfg_rst", q, cfg);
    bus(1'b0, FMU_OFF_PSTATUS, 32'h0);
    chk("pst_rst", q, 32'h4);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    // Lane 0 only: upper attribute fields must keep their reset values
    be <= 4'h1;
    bus(1'b1, FMU_OFF_CONFIG, 32'h7E00_0007);
    be <= 4'hF;
    bus(1'b0, FMU_OFF_CONFIG, 32'h0);
    chk("cfg_lane", q, 32'h2400_0007);
    bus(1'b1, FMU_OFF_PSTATUS, 32'h0);
    error_level_flag = 1'b0;
    repeat (2) @(negedge clk);
    chk("erl_clr", {31'h0, erl_o}, 32'h0);
    for (int k = 0; k < 8; k++) begin
      cfg = 32'h0;
      cfg[30:28] = k[2:0];
      cfg[27:25] = k[2:0] + 3'h1;
      cfg[2:0] = k[2:0] + 3'h2;
      bus(1'b1, FMU_OFF_CONFIG, cfg);
      repeat (12) xl($urandom % 2, $urandom, $urandom % 4);
    end
    bus(1'b1, FMU_OFF_PSTATUS, 32'h4);
    error_level_flag = 1'b1;
    repeat (10) xl($urandom % 2, $urandom & 32'h7FFF_FFFF, $urandom % 4);
    pipe.issue(1'b0, 32'h0, 2'h0);
    bus(1'b1, FMU_OFF_EVENT, 32'h3);
    bus(1'b1, FMU_OFF_MASK, 32'h1);
    xl(1'b1, 32'h8000_0000, 2'h2);
    pipe.issue(1'b0, 32'h0, 2'h0);
    wirq(1'b1);
    bus(1'b0, FMU_OFF_EVENT, 32'h0);
    chk("event", q, 32'h1);
    bus(1'b0, FMU_OFF_ERR_VA, 32'h0);
    chk("err_va", q, 32'h8000_0000);
    bus(1'b1, FMU_OFF_EVENT, 32'h1);
    wirq(1'b0);
    // Masked event must stay silent until enabled
    xl(1'b1, 32'h0000_1000, 2'h0);
    pipe.issue(1'b0, 32'h0, 2'h0);
    repeat (3) @(negedge clk);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    bus(1'b0, FMU_OFF_EVENT, 32'h0);
    chk("event_erl", q, 32'h2);
    bus(1'b1, FMU_OFF_MASK, 32'h3);
    wirq(1'b1);
    finish_test();
  end
endmodule
bind fmu_top fmu_top_chk chk (.*);
